// ### src/fpc_defines.svh
// Constants for the fast pulse counter block: pin counts, field widths,
// mode codes and timing figures.
// Assumes nothing; included by the package and the design files.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

`define FPC_NUM_CNT        4
`define FPC_NUM_DOUT       12
`define FPC_CNT_W          32
`define FPC_CPR_W          28
`define FPC_CPR_MAX        28'hfffffff
`define FPC_GATE_W         20

// Clock and count base
`define FPC_CLK_PERIOD_NS  8
`define FPC_US_NS          1000
`define FPC_US_CYC         ((`FPC_US_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)
`define FPC_US_DIV_W       7

// Frequency gate lengths in microseconds
`define FPC_GATE_1S_US     1000000
`define FPC_GATE_100MS_US  100000
`define FPC_GATE_10MS_US   10000

// Frequency modes
`define FPC_FREQ_1S        4'h0
`define FPC_FREQ_100MS     4'h1
`define FPC_FREQ_10MS      4'h2
`define FPC_FREQ_SCAN      4'h3
// Totalize modes
`define FPC_TOT_RISE       4'h0
`define FPC_TOT_FALL       4'h1
// Pulse modes
`define FPC_PUL_HIGH       4'h0
`define FPC_PUL_LOW        4'h1
`define FPC_PUL_PER_RISE   4'h2
`define FPC_PUL_PER_FALL   4'h3
// Quadrature modes
`define FPC_QUAD_LEAD_UP   4'h0
`define FPC_QUAD_LEAD_DN   4'h1
// Marker modes: async codes, qualified codes carry bit 3 set
`define FPC_MK_RISE        4'h0
`define FPC_MK_FALL        4'h1
`define FPC_MK_BOTH        4'h2
`define FPC_MK_QUAL_BIT    3
`define FPC_MK_PHASE_BIT   2
`define FPC_MK_EFALL_BIT   1
`define FPC_MK_LOW_BIT     0

// Counter roles in the marker pairing
`define FPC_QUAD_CH        0
`define FPC_MARK_CH        2

`endif

// ### src/fpc_pkg.sv
// Types shared by the fast pulse counter block.
// Assumes fpc_defines.svh is on the include path.
`include "fpc_defines.svh"

package fpc_pkg;

   typedef enum logic [2:0] {
      FPC_T_DIS   = 3'h0,
      FPC_T_FREQ  = 3'h1,
      FPC_T_TOT   = 3'h2,
      FPC_T_PULSE = 3'h3,
      FPC_T_QUAD  = 3'h4,
      FPC_T_MARK  = 3'h5
   } fpc_type_t;

   typedef struct packed {
      fpc_type_t               ctype;
      logic [3:0]              mode;
      logic [`FPC_CPR_W-1:0]   cpr;
   } fpc_cfg_t;

   typedef struct packed {
      logic [`FPC_CNT_W-1:0]   acc;
      logic [`FPC_CNT_W-1:0]   val;
      logic [`FPC_GATE_W-1:0]  gate;
      logic                    pa;
      logic                    pb;
   } fpc_ch_st_t;

   typedef struct packed {
      logic [`FPC_NUM_CNT-1:0]   in_q;
      logic [`FPC_NUM_CNT-1:0]   in_p;
      logic [`FPC_NUM_CNT-1:0]   img;
      logic [`FPC_US_DIV_W-1:0]  usdiv;
      logic                      us_tick;
      logic                      mk_clr;
      logic                      ran;
      logic                      mfo1;
      logic                      mfo2;
      logic [`FPC_NUM_DOUT-1:0]  dout;
   } fpc_top_st_t;

endpackage

// ### src/fpc_channel.sv
// One fast pulse counter channel: frequency, totalize, pulse and
// quadrature measurement on conditioned input levels.
// Assumes inputs are already synchronous and polarity corrected.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defines.svh"

module fpc_channel
   import fpc_pkg::*;
#(
   parameter logic [`FPC_GATE_W-1:0] GATE_1S    = `FPC_GATE_W'(`FPC_GATE_1S_US),
   parameter logic [`FPC_GATE_W-1:0] GATE_100MS = `FPC_GATE_W'(`FPC_GATE_100MS_US),
   parameter logic [`FPC_GATE_W-1:0] GATE_10MS  = `FPC_GATE_W'(`FPC_GATE_10MS_US)
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire fpc_cfg_t              cfg,
   input  wire logic                  in_a,
   input  wire logic                  in_b,
   input  wire logic                  us_tick,
   input  wire logic                  scan_tick,
   input  wire logic                  clear,
   output logic [`FPC_CNT_W-1:0]      value
);

   fpc_ch_st_t q, d;

   logic                   rise, fall, edge_hit, tick_en, gate_end, fwd, rev, step_up, step_dn;
   logic [`FPC_GATE_W-1:0] glen;
   logic [`FPC_CNT_W-1:0]  lim;
   logic [3:0]             trans;

   // Edge and quadrature transition decode
   always_comb begin
      rise  = in_a & ~q.pa;
      fall  = ~in_a & q.pa;
      trans = {q.pa, q.pb, in_a, in_b};
      fwd   = (trans == 4'h2) | (trans == 4'hb) | (trans == 4'hd) | (trans == 4'h4);
      rev   = (trans == 4'h1) | (trans == 4'h7) | (trans == 4'he) | (trans == 4'h8);
      lim   = {{(`FPC_CNT_W-`FPC_CPR_W){1'b0}}, cfg.cpr};
      case (cfg.mode)
         `FPC_FREQ_1S:    glen = GATE_1S;
         `FPC_FREQ_100MS: glen = GATE_100MS;
         default:         glen = GATE_10MS;
      endcase
   end

   // Next state per counter type
   always_comb begin
      d        = q;
      d.pa     = in_a;
      d.pb     = in_b;
      edge_hit = 1'b0;
      tick_en  = 1'b0;
      gate_end = 1'b0;
      step_up  = 1'b0;
      step_dn  = 1'b0;
      case (cfg.ctype)
         FPC_T_FREQ: begin
            // Gate by microsecond count or by program scan
            if (cfg.mode == `FPC_FREQ_SCAN) begin
               gate_end = scan_tick;
            end else if (us_tick) begin
               gate_end = (q.gate >= glen - 1'b1);
               d.gate   = gate_end ? '0 : q.gate + 1'b1;
            end
            if (rise) begin
               d.acc = q.acc + 1'b1;
            end
            if (gate_end) begin
               d.val = q.acc + {{(`FPC_CNT_W-1){1'b0}}, rise};
               d.acc = '0;
            end
         end
         FPC_T_TOT: begin
            edge_hit = (cfg.mode == `FPC_TOT_FALL) ? fall : rise;
            if (edge_hit) begin
               // Limit of zero means free running
               d.acc = (lim != '0 && q.acc >= lim) ? '0 : q.acc + 1'b1;
            end
            d.val = d.acc;
         end
         FPC_T_PULSE: begin
            case (cfg.mode)
               `FPC_PUL_HIGH: begin
                  tick_en  = q.pa;
                  edge_hit = fall;
               end
               `FPC_PUL_LOW: begin
                  tick_en  = ~q.pa;
                  edge_hit = rise;
               end
               `FPC_PUL_PER_RISE: begin
                  tick_en  = 1'b1;
                  edge_hit = rise;
               end
               default: begin
                  tick_en  = 1'b1;
                  edge_hit = fall;
               end
            endcase
            // Result in microsecond counts, latched at the closing edge
            if (edge_hit) begin
               d.val = q.acc;
               d.acc = '0;
            end else if (us_tick && tick_en && q.acc != '1) begin
               d.acc = q.acc + 1'b1; // Saturates on a stuck input
            end
         end
         FPC_T_QUAD: begin
            step_up = (cfg.mode == `FPC_QUAD_LEAD_UP) ? fwd : rev;
            step_dn = (cfg.mode == `FPC_QUAD_LEAD_UP) ? rev : fwd;
            if (clear) begin
               d.acc = '0;
            end else if (step_up) begin
               d.acc = (lim != '0 && q.acc >= lim) ? '0 : q.acc + 1'b1;
            end else if (step_dn) begin
               d.acc = (q.acc == '0) ? lim : q.acc - 1'b1;
            end
            d.val = d.acc;
         end
         default: begin
            // Disabled and marker channels count nothing
            d.acc  = '0;
            d.val  = '0;
            d.gate = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign value = q.val;

endmodule

`default_nettype wire

// ### src/fpc_top.sv
// Fast pulse counter block: four counters on the digital inputs, input
// polarity, marker reset and stop behaviour of the multifunction and
// plain digital outputs.
// Assumes pins, run and download controls are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defines.svh"

module fpc_top
   import fpc_pkg::*;
#(
   parameter logic [`FPC_GATE_W-1:0] GATE_1S    = `FPC_GATE_W'(`FPC_GATE_1S_US),
   parameter logic [`FPC_GATE_W-1:0] GATE_100MS = `FPC_GATE_W'(`FPC_GATE_100MS_US),
   parameter logic [`FPC_GATE_W-1:0] GATE_10MS  = `FPC_GATE_W'(`FPC_GATE_10MS_US)
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic [`FPC_NUM_CNT-1:0]       din,
   input  wire logic                          active_low,
   input  wire fpc_cfg_t [`FPC_NUM_CNT-1:0]   cnt_cfg,
   input  wire logic                          scan_tick,
   input  wire logic                          ctl_run,
   input  wire logic                          ctl_download,
   input  wire logic [1:0]                    pwm_level,
   input  wire logic [1:0]                    pwm_hold,
   input  wire logic [1:0]                    pwm_default,
   input  wire logic [`FPC_NUM_DOUT-1:0]      dout_level,
   input  wire logic [`FPC_NUM_DOUT-1:0]      dout_hold,
   input  wire logic [`FPC_NUM_DOUT-1:0]      dout_default,
   output logic [`FPC_NUM_CNT-1:0][`FPC_CNT_W-1:0] cnt_value,
   output logic [`FPC_NUM_CNT-1:0]            plain_input_image_bit,
   output logic                               multifunction_output_one,
   output logic                               multifunction_output_two,
   output logic [`FPC_NUM_DOUT-1:0]           dout
);

   localparam logic [`FPC_US_DIV_W-1:0] US_LAST = `FPC_US_DIV_W'(`FPC_US_CYC - 1);

   fpc_top_st_t q, d;

   logic     mk_ok;
   logic     mk_now, mk_was, mk_rise, mk_fall;
   logic     ph_now, ph_was, ph_edge, lvl_ok;
   fpc_cfg_t cfg_mk;

   // Marker pairing is only valid with counter 1 in quadrature
   always_comb begin
      mk_ok  = (cnt_cfg[`FPC_MARK_CH].ctype == FPC_T_MARK) &&
               (cnt_cfg[`FPC_QUAD_CH].ctype == FPC_T_QUAD);
      cfg_mk = cnt_cfg[`FPC_MARK_CH];
      mk_now = q.in_q[`FPC_MARK_CH];
      mk_was = q.in_p[`FPC_MARK_CH];
      mk_rise = mk_now & ~mk_was;
      mk_fall = ~mk_now & mk_was;
      // Qualified modes look at a phase of counter 1
      ph_now = cfg_mk.mode[`FPC_MK_PHASE_BIT] ? q.in_q[`FPC_QUAD_CH+1] : q.in_q[`FPC_QUAD_CH];
      ph_was = cfg_mk.mode[`FPC_MK_PHASE_BIT] ? q.in_p[`FPC_QUAD_CH+1] : q.in_p[`FPC_QUAD_CH];
      ph_edge = cfg_mk.mode[`FPC_MK_EFALL_BIT] ? (~ph_now & ph_was) : (ph_now & ~ph_was);
      lvl_ok  = cfg_mk.mode[`FPC_MK_LOW_BIT] ? ~mk_now : mk_now;
   end

   // Next state of the shared logic
   always_comb begin
      d = q;

      // Polarity correction at the pin register
      d.in_q = din ^ {`FPC_NUM_CNT{active_low}};
      d.in_p = q.in_q;

      // Microsecond count base shared by all counters
      if (q.usdiv == US_LAST) begin
         d.usdiv   = '0;
         d.us_tick = 1'b1;
      end else begin
         d.usdiv   = q.usdiv + 1'b1;
         d.us_tick = 1'b0;
      end

      // Marker clear pulse towards the quadrature counter
      d.mk_clr = 1'b0;
      if (mk_ok) begin
         if (cfg_mk.mode[`FPC_MK_QUAL_BIT]) begin
            d.mk_clr = lvl_ok & ph_edge;
         end else begin
            case (cfg_mk.mode)
               `FPC_MK_RISE: d.mk_clr = mk_rise;
               `FPC_MK_FALL: d.mk_clr = mk_fall;
               `FPC_MK_BOTH: d.mk_clr = mk_rise | mk_fall;
               default:      d.mk_clr = 1'b0;
            endcase
         end
      end

      // Plain input image for disabled counters only; marker counters read as zero
      for (int i = 0; i < `FPC_NUM_CNT; i++) begin
         d.img[i] = (cnt_cfg[i].ctype == FPC_T_DIS) ? q.in_q[i] : 1'b0;
      end

      // Run history: download wipes it, run sets it
      if (ctl_download) begin
         d.ran = 1'b0;
      end else if (ctl_run) begin
         d.ran = 1'b1;
      end

      // Multifunction outputs stay off until the first run after load
      if (!q.ran || ctl_download) begin
         d.mfo1 = 1'b0;
         d.mfo2 = 1'b0;
      end else if (ctl_run) begin
         d.mfo1 = pwm_level[0];
         d.mfo2 = pwm_level[1];
      end else begin
         d.mfo1 = pwm_hold[0] ? q.mfo1 : pwm_default[0];
         d.mfo2 = pwm_hold[1] ? q.mfo2 : pwm_default[1];
      end

      // Plain outputs follow the program only while running
      if (ctl_run && !ctl_download) begin
         d.dout = dout_level;
      end else begin
         for (int j = 0; j < `FPC_NUM_DOUT; j++) begin
            d.dout[j] = dout_hold[j] ? q.dout[j] : dout_default[j];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // One channel per counter; phase 2 is the next pin up, counter 4 wrapping to pin 1
   for (genvar g = 0; g < `FPC_NUM_CNT; g++) begin : g_ch
      fpc_channel #(
         .GATE_1S    (GATE_1S),
         .GATE_100MS (GATE_100MS),
         .GATE_10MS  (GATE_10MS)
      ) u_ch (
         .sys_clk   (sys_clk),
         .rst       (rst),
         .cfg       (cnt_cfg[g]),
         .in_a      (q.in_q[g]),
         .in_b      (q.in_q[(g + 1) % `FPC_NUM_CNT]),
         .us_tick   (q.us_tick),
         .scan_tick (scan_tick),
         .clear     ((g == `FPC_QUAD_CH) ? q.mk_clr : 1'b0),
         .value     (cnt_value[g])
      );
   end

   // All outputs straight from registers
   assign plain_input_image_bit    = q.img;
   assign multifunction_output_one = q.mfo1;
   assign multifunction_output_two = q.mfo2;
   assign dout                     = q.dout;

endmodule

`default_nettype wire

// ### testbench/fpc_src_model.sv
// Source model for the counter pins: encoder phases, marker, pulse trains.
// Assumes callers run in the sys_clk domain; pins change 1 ns after an edge.
`timescale 1ns/10ps
`default_nettype none
module fpc_src_model (
   input  wire logic  sys_clk,
   output logic [3:0] pins
);
   initial pins = 4'h0;
   // Wait n edges, then step just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic level(input logic [3:0] v);
      pins = v;
   endtask
   task automatic set_pin(input int ch, input logic v);
      pins[ch] = v;
   endtask
   // High for hi cycles, then low for lo cycles
   task automatic pulse(input int ch, input int hi, input int lo);
      pins[ch] = 1'b1;
      tick(hi);
      pins[ch] = 1'b0;
      tick(lo);
   endtask
   // Gray steps only, each held 4 cycles; a two-bit jump would be dropped
   task automatic quad(input int n, input logic lead1);
      for (int i = 0; i < n; i++) begin
         pins[1:0] = lead1 ? {pins[0], ~pins[1]} : {~pins[0], pins[1]};
         tick(4);
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/fpc_top_assertions.sv
// Checker for the fast pulse counter top: output timing against inputs.
// Assumes only the top's ports; bound to every fpc_top below.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_top_assertions
   import fpc_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic [3:0]            din,
   input wire logic                  active_low,
   input wire fpc_cfg_t [3:0]        cnt_cfg,
   input wire logic                  scan_tick,
   input wire logic                  ctl_run,
   input wire logic                  ctl_download,
   input wire logic [1:0]            pwm_level,
   input wire logic [1:0]            pwm_hold,
   input wire logic [1:0]            pwm_default,
   input wire logic [11:0]           dout_level,
   input wire logic [11:0]           dout_hold,
   input wire logic [11:0]           dout_default,
   input wire logic [3:0][31:0]      cnt_value,
   input wire logic [3:0]            plain_input_image_bit,
   input wire logic                  multifunction_output_one,
   input wire logic                  multifunction_output_two,
   input wire logic [11:0]           dout
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic tr0;
   logic qu0;
   logic mk;
   // Step checks only hold with no wrap limit and plain polarity
   assign tr0 = cnt_cfg[0].ctype == FPC_T_TOT && cnt_cfg[0].mode == `FPC_TOT_RISE
                && cnt_cfg[0].cpr == 28'h0 && !active_low;
   assign qu0 = cnt_cfg[0].ctype == FPC_T_QUAD && cnt_cfg[0].mode == `FPC_QUAD_LEAD_UP
                && cnt_cfg[0].cpr == 28'h0 && !active_low && cnt_cfg[2].ctype != FPC_T_MARK;
   assign mk = cnt_cfg[0].ctype == FPC_T_QUAD && cnt_cfg[2].ctype == FPC_T_MARK
               && cnt_cfg[2].mode == `FPC_MK_RISE && !active_low;
   // Output relations
   chk_mfo_dl_off: assert property (ctl_download |=> !multifunction_output_one && !multifunction_output_two)
      else $error("multifunction output on during download");
   chk_mfo_hold: assert property (!ctl_run && !ctl_download && pwm_hold[0] |=> $stable(multifunction_output_one))
      else $error("held multifunction output moved");
   chk_mfo_default: assert property ($past(ctl_run) && !ctl_run && !ctl_download && !pwm_hold[1]
      && !$past(ctl_download) |=> multifunction_output_two == $past(pwm_default[1]))
      else $error("stop default not applied");
   chk_dout_run: assert property (ctl_run && !ctl_download |=> dout == $past(dout_level))
      else $error("digital output not following level");
   chk_dout_stop: assert property (!ctl_run || ctl_download |=> dout == (($past(dout) & $past(dout_hold))
      | ($past(dout_default) & ~$past(dout_hold)))) else $error("stop hold or default wrong");
   chk_img_count: assert property ((cnt_cfg[0].ctype != FPC_T_DIS) [*2] |=> !plain_input_image_bit[0])
      else $error("image bit set on counting input");
   chk_tot_step: assert property (tr0 && $rose(din[0]) |-> ##2 cnt_value[0] == $past(cnt_value[0], 2) + 32'h1)
      else $error("totalize step missing");
   chk_quad_up: assert property ((qu0 && din[1:0] == 2'h1) [*2] ##1 din[1:0] == 2'h3
      |-> ##2 cnt_value[0] == $past(cnt_value[0], 2) + 32'h1) else $error("quadrature up step missing");
   chk_mark_clear: assert property (mk && $rose(din[2]) |-> ##3 cnt_value[0] == 32'h0)
      else $error("marker did not clear count");
   cov_tot: cover property (tr0 && $rose(din[0]));
   cov_mark: cover property (mk && $rose(din[2]));
   cov_stop: cover property ($fell(ctl_run) && !ctl_download);
endmodule
bind fpc_top fpc_top_assertions u_chk (.*);
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the fast pulse counter top.
// Assumes the source model drives the pins; short gates of 20/10/5 us.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defines.svh"
module testbench
   import fpc_pkg::*;
;
   logic             sys_clk = 1'b0;
   logic             rst = 1'b1;
   logic             active_low = 1'b0;
   logic             scan_tick = 1'b0;
   logic             ctl_run = 1'b0;
   logic             ctl_download = 1'b0;
   logic [1:0]       pwm_level = 2'h0;
   logic [1:0]       pwm_hold = 2'h0;
   logic [1:0]       pwm_default = 2'h0;
   logic [11:0]      dout_level = 12'h0;
   logic [11:0]      dout_hold = 12'h0;
   logic [11:0]      dout_default = 12'h0;
   fpc_cfg_t [3:0]   cnt_cfg = '0;
   wire logic [3:0]  din;
   logic [3:0][31:0] cnt_value;
   logic [3:0]       img;
   logic             mfo1;
   logic             mfo2;
   logic [11:0]      dout;
   int               n_mismatch = 0;
   int               total_checks = 0;
   always #4 sys_clk = ~sys_clk;
   fpc_src_model u_src (.sys_clk(sys_clk), .pins(din));
   fpc_top #(.GATE_1S(20'h14), .GATE_100MS(20'ha), .GATE_10MS(20'h5)) dut (
      .sys_clk(sys_clk), .rst(rst), .din(din), .active_low(active_low), .cnt_cfg(cnt_cfg),
      .scan_tick(scan_tick), .ctl_run(ctl_run), .ctl_download(ctl_download), .pwm_level(pwm_level),
      .pwm_hold(pwm_hold), .pwm_default(pwm_default), .dout_level(dout_level), .dout_hold(dout_hold),
      .dout_default(dout_default), .cnt_value(cnt_value), .plain_input_image_bit(img),
      .multifunction_output_one(mfo1), .multifunction_output_two(mfo2), .dout(dout));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Fresh state for each scenario, so no count leaks between them
   task automatic restart();
      rst = 1'b1;
      cnt_cfg = '0;
      u_src.level(4'h0);
      cyc(3);
      rst = 1'b0;
   endtask
   task automatic t_plain();
      restart();
      u_src.level(4'h5);
      cyc(4);
      chk("image", 32'h5, 32'(img));
      chk("idle count", 32'h0, cnt_value[0]);
      active_low = 1'b1;
      cyc(4);
      chk("image inverted", 32'ha, 32'(img));
      active_low = 1'b0;
   endtask
   task automatic t_tot();
      restart();
      cnt_cfg[0] = '{FPC_T_TOT, `FPC_TOT_RISE, 28'h0};
      // Limit of one on counter 4: three edges wrap 0, 1, 0, 1
      cnt_cfg[3] = '{FPC_T_TOT, `FPC_TOT_RISE, 28'h1};
      repeat (5) u_src.pulse(0, 2, 2);
      repeat (3) u_src.pulse(3, 3, 3);
      cyc(4);
      chk("tot rise", 32'h5, cnt_value[0]);
      chk("tot ch3", 32'h1, cnt_value[3]);
      cnt_cfg[0].mode = `FPC_TOT_FALL;
      repeat (3) u_src.pulse(0, 2, 2);
      cyc(4);
      chk("tot fall", 32'h8, cnt_value[0]);
   endtask
   task automatic t_quad();
      restart();
      cnt_cfg[0] = '{FPC_T_QUAD, `FPC_QUAD_LEAD_UP, 28'h0};
      u_src.quad(6, 1'b1);
      u_src.quad(2, 1'b0);
      cyc(4);
      chk("quad up", 32'h4, cnt_value[0]);
      cnt_cfg[0] = '{FPC_T_QUAD, `FPC_QUAD_LEAD_DN, `FPC_CPR_MAX};
      u_src.quad(5, 1'b1);
      cyc(4);
      chk("quad wrap down", 32'h0fffffff, cnt_value[0]);
      u_src.quad(1, 1'b0);
      cyc(4);
      chk("quad wrap up", 32'h0, cnt_value[0]);
   endtask
   task automatic t_mark();
      restart();
      cnt_cfg[0] = '{FPC_T_QUAD, `FPC_QUAD_LEAD_UP, 28'h0};
      cnt_cfg[2] = '{FPC_T_MARK, `FPC_MK_RISE, 28'h0};
      u_src.quad(5, 1'b1);
      u_src.pulse(2, 3, 3);
      cyc(4);
      chk("mark async", 32'h0, cnt_value[0]);
      cnt_cfg[2].mode = 4'h8; // Qualified: phase 1 rising, marker high
      u_src.quad(3, 1'b1);
      cyc(4);
      chk("mark low", 32'h3, cnt_value[0]);
      u_src.set_pin(2, 1'b1);
      u_src.quad(1, 1'b1);
      cyc(4);
      chk("mark qual", 32'h0, cnt_value[0]);
      chk("mark ch", 32'h0, cnt_value[2]);
      // Async falling edge clear
      cnt_cfg[2].mode = `FPC_MK_FALL;
      u_src.quad(2, 1'b1);
      u_src.set_pin(2, 1'b0);
      cyc(4);
      chk("mark fall", 32'h0, cnt_value[0]);
      // Both edges: each one must clear a nonzero count
      cnt_cfg[2].mode = `FPC_MK_BOTH;
      u_src.quad(2, 1'b1);
      u_src.set_pin(2, 1'b1);
      cyc(4);
      chk("mark both rise", 32'h0, cnt_value[0]);
      u_src.quad(1, 1'b1);
      u_src.set_pin(2, 1'b0);
      cyc(4);
      chk("mark both fall", 32'h0, cnt_value[0]);
      // Qualified: phase 2 falling, marker low
      cnt_cfg[2].mode = 4'hf;
      u_src.quad(1, 1'b1);
      chk("mark ph2 wait", 32'h1, cnt_value[0]);
      u_src.quad(1, 1'b1);
      cyc(4);
      chk("mark ph2", 32'h0, cnt_value[0]);
      restart();
      cnt_cfg[0] = '{FPC_T_TOT, `FPC_TOT_RISE, 28'h0};
      cnt_cfg[2] = '{FPC_T_MARK, `FPC_MK_RISE, 28'h0};
      repeat (2) u_src.pulse(0, 2, 2);
      u_src.pulse(2, 3, 3);
      cyc(4);
      chk("mark refused", 32'h2, cnt_value[0]);
      // Marker type on counter 4 must never clear counter 1
      restart();
      cnt_cfg[0] = '{FPC_T_QUAD, `FPC_QUAD_LEAD_UP, 28'h0};
      cnt_cfg[3] = '{FPC_T_MARK, `FPC_MK_RISE, 28'h0};
      u_src.quad(2, 1'b1);
      u_src.pulse(3, 3, 3);
      cyc(4);
      chk("mark off ch", 32'h2, cnt_value[0]);
      chk("mark off val", 32'h0, cnt_value[3]);
   endtask
   // Pulse period of 125 cycles gives a whole count in any gate
   task automatic t_freq();
      int n [3] = '{20, 10, 5};
      for (int m = 0; m < 3; m++) begin
         restart();
         cnt_cfg[1] = '{FPC_T_FREQ, 4'(m), 28'h3};
         repeat (n[m] * 5 / 2) u_src.pulse(1, 62, 63);
         chk("freq gate", 32'(n[m]), cnt_value[1]);
      end
      restart();
      cnt_cfg[1] = '{FPC_T_FREQ, `FPC_FREQ_SCAN, 28'h0};
      for (int k = 0; k < 2; k++) begin
         scan_tick = 1'b1;
         cyc(1);
         scan_tick = 1'b0;
         if (k == 0) repeat (7) u_src.pulse(1, 3, 3);
         cyc(4);
      end
      chk("freq scan", 32'h7, cnt_value[1]);
   endtask
   task automatic t_pulse();
      int w [4] = '{3, 2, 5, 5};
      for (int m = 0; m < 4; m++) begin
         restart();
         cnt_cfg[1] = '{FPC_T_PULSE, 4'(m), 28'h0};
         repeat (3) u_src.pulse(1, 375, 250);
         cyc(4);
         chk("pulse us", 32'(w[m]), cnt_value[1]);
      end
   endtask
   task automatic t_out();
      restart();
      pwm_level = 2'h1;
      dout_level = 12'ha5a;
      cyc(3);
      chk("mfo idle", 32'h0, 32'({mfo2, mfo1}));
      ctl_run = 1'b1;
      cyc(3);
      chk("mfo run", 32'h1, 32'({mfo2, mfo1}));
      chk("dout run", 32'ha5a, 32'(dout));
      pwm_hold = 2'h1;
      pwm_default = 2'h2;
      dout_hold = 12'h0f0;
      dout_default = 12'hf00;
      ctl_run = 1'b0;
      cyc(3);
      chk("mfo stop", 32'h3, 32'({mfo2, mfo1}));
      chk("dout stop", 32'hf50, 32'(dout));
      ctl_download = 1'b1;
      cyc(3);
      chk("mfo download", 32'h0, 32'({mfo2, mfo1}));
      ctl_download = 1'b0;
      cyc(3);
      chk("mfo after load", 32'h0, 32'({mfo2, mfo1}));
   endtask
   task automatic final_report();
      $display("TB: checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Cut a hang short
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_mismatch++;
      $display("MISMATCH watchdog expected done seen running");
      final_report();
   end
   initial begin
      #1;
      t_plain();
      t_tot();
      t_quad();
      t_mark();
      t_freq();
      t_pulse();
      t_out();
      final_report();
   end
endmodule
`default_nettype wire
